// ===== src/asb_sample_buffer.sv
// Purpose: mode-aware three-axis sample buffer (fifo, stream, trigger, filo)
// Assumes: sample bytes arrive in order through a valid/ready byte port
// Notes:   host reads take one whole sample per request

`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - past the threshold, new samples keep being written sequentially (trigger: after trigger)
// - fifo mode, and trigger mode after trigger, drop new samples when full, contents kept
// - stream and filo modes discard the oldest sample to fit a new one when full
// - fifo, stream, trigger reads remove the oldest sample
// - filo reads remove only the newest sample
// - watermark is high while count is at or above a nonzero threshold
// - trigger mode before trigger keeps a fixed history by discarding oldest
// - after trigger, stop discarding and fill until full
// - high resolution samples are six bytes taken in order
module asb_sample_buffer #(
  parameter int unsigned DEPTH   = asb_pkg::SMP_DEPTH,
  parameter int unsigned IN_DPTH = asb_pkg::IN_FIFO_DEPTH,
  localparam int unsigned CW     = $clog2(DEPTH + 1),
  localparam int unsigned PW     = $clog2(DEPTH)
) (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire asb_pkg::asb_mode_t mode,
  input  wire logic               res_high,
  input  wire logic [CW-1:0]      thresh,
  input  wire logic               clear,
  input  wire logic               trigger,
  input  wire logic               in_valid,
  input  wire logic [7:0]         in_byte,
  output logic                    in_ready,
  input  wire logic               rd_req,
  output asb_pkg::asb_rd_rsp_t    rd_rsp,
  output logic                    wmk,
  output logic                    full,
  output logic                    empty,
  output logic                    trig_seen,
  output logic [CW-1:0]           count
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (DEPTH < 2 || IN_DPTH < 2) begin : g_bad_param
    $error("asb_sample_buffer: DEPTH and IN_DPTH must be at least 2");
  end

  // wrap a pointer forward by n places
  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [CW-1:0] n);
    logic [CW:0] s;
    s = (CW+1)'(p) + (CW+1)'(n);
    if (s >= (CW+1)'(DEPTH)) begin
      s = s - (CW+1)'(DEPTH);
    end
    return PW'(s);
  endfunction

  asb_pkg::asb_sample_t mem_r [DEPTH];
  logic [PW-1:0]        head_r;
  logic [CW-1:0]        count_r;
  logic                 trig_seen_r;
  logic [2:0]           byte_cnt_r;
  asb_pkg::asb_sample_t asm_r;
  asb_pkg::asb_rd_rsp_t rd_rsp_r;
  logic                 f_valid;
  logic [7:0]           f_byte;
  logic                 f_ready;
  logic                 pop;
  logic                 commit;
  logic [2:0]           last_idx;
  asb_pkg::asb_sample_t smp_in;
  logic                 thr_hit;
  logic                 wr_en;
  logic                 drop_old;
  logic                 rd_do;

  // ****************************************
  // byte intake
  // ****************************************
  asb_byte_fifo #(
    .WIDTH (asb_pkg::BYTE_W),
    .DEPTH (IN_DPTH)
  ) u_in_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (in_valid),
    .in_data   (in_byte),
    .in_ready  (in_ready),
    .out_valid (f_valid),
    .out_data  (f_byte),
    .out_ready (f_ready)
  );

  // host reads and clears take the cycle, so intake stalls and never collides with them
  assign f_ready  = !rd_req && !clear;
  assign pop      = f_valid && f_ready;
  assign last_idx = res_high ? 3'(asb_pkg::SMP_BYTES_HI - 1) : 3'(asb_pkg::SMP_BYTES_LO - 1);
  assign commit   = pop && (byte_cnt_r == last_idx);

  // final byte merged in place so the sample commits on the same edge
  always_comb begin
    smp_in = asm_r;
    smp_in[byte_cnt_r*asb_pkg::BYTE_W +: asb_pkg::BYTE_W] = f_byte;
  end

  // assemble bytes in arrival order; a clear throws away a half sample
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      byte_cnt_r <= '0;
      asm_r      <= '0;
    end else if (clear) begin
      byte_cnt_r <= '0;
      asm_r      <= '0;
    end else if (pop) begin
      asm_r[byte_cnt_r*asb_pkg::BYTE_W +: asb_pkg::BYTE_W] <= f_byte;
      byte_cnt_r <= commit ? 3'd0 : byte_cnt_r + 3'd1;
      if (commit) begin
        asm_r <= '0;
      end
    end
  end

  // ****************************************
  // mode policy
  // ****************************************
  assign full    = (count_r == CW'(DEPTH));
  assign empty   = (count_r == '0);
  assign thr_hit = (thresh != '0) && (count_r >= thresh);

  // decide whether a finished sample is stored and whether the oldest goes
  always_comb begin
    wr_en    = 1'b0;
    drop_old = 1'b0;
    if (commit) begin
      unique case (mode)
        asb_pkg::ASB_MODE_FIFO: begin
          wr_en = !full;
        end
        asb_pkg::ASB_MODE_STREAM, asb_pkg::ASB_MODE_FILO: begin
          wr_en    = 1'b1;
          drop_old = full;
        end
        asb_pkg::ASB_MODE_TRIGGER: begin
          if (!trig_seen_r) begin
            wr_en    = 1'b1;
            drop_old = thr_hit || full;
          end else begin
            wr_en = !full;
          end
        end
      endcase
    end
  end

  assign rd_do = rd_req && !empty && !clear;

  // ****************************************
  // sample store
  // ****************************************
  // new sample lands just past the newest; when a full buffer drops the oldest that slot is reused
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_r[ptr_add(head_r, count_r)] <= asb_pkg::asb_sample_t'(smp_in);
    end
  end

  // head moves on a discard or an oldest-first read, never on a filo read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      head_r <= '0;
    end else if (clear) begin
      head_r <= '0;
    end else if ((wr_en && drop_old) || (rd_do && mode != asb_pkg::ASB_MODE_FILO)) begin
      head_r <= ptr_add(head_r, CW'(1));
    end
  end

  // stored sample count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
    end else if (clear) begin
      count_r <= '0;
    end else if (rd_do) begin
      count_r <= count_r - CW'(1);
    end else if (wr_en && !drop_old) begin
      count_r <= count_r + CW'(1);
    end
  end

  // trigger latch; a trigger in the clear cycle still counts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trig_seen_r <= 1'b0;
    end else if (trigger && mode == asb_pkg::ASB_MODE_TRIGGER) begin
      trig_seen_r <= 1'b1;
    end else if (clear) begin
      trig_seen_r <= 1'b0;
    end
  end

  // ****************************************
  // host read port
  // ****************************************
  // filo reads the newest slot, others the oldest
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_rsp_r <= '0;
    end else begin
      rd_rsp_r.valid <= rd_do;
      if (rd_do) begin
        rd_rsp_r.sample <= (mode == asb_pkg::ASB_MODE_FILO)
                         ? mem_r[ptr_add(head_r, count_r - CW'(1))]
                         : mem_r[head_r];
      end
    end
  end

  assign rd_rsp    = rd_rsp_r;
  assign wmk       = thr_hit;
  assign trig_seen = trig_seen_r;
  assign count     = count_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_seq_fill: assert property (commit && !full && mode != asb_pkg::ASB_MODE_TRIGGER
    |=> count_r == $past(count_r) + 1) else $error("sample not appended");
  a_full_stop: assert property (commit && full && (mode == asb_pkg::ASB_MODE_FIFO
    || (mode == asb_pkg::ASB_MODE_TRIGGER && trig_seen_r))
    |=> full && $stable(head_r)) else $error("full buffer changed");
  a_full_discard: assert property (commit && full && (mode == asb_pkg::ASB_MODE_STREAM
    || mode == asb_pkg::ASB_MODE_FILO)
    |=> full && head_r == ptr_add($past(head_r), CW'(1))) else $error("oldest not discarded");
  a_oldest_read: assert property (rd_do && mode != asb_pkg::ASB_MODE_FILO
    |=> count_r == $past(count_r) - 1 && rd_rsp.valid && head_r != $past(head_r))
    else $error("oldest read wrong");
  a_newest_read: assert property (rd_do && mode == asb_pkg::ASB_MODE_FILO
    |=> count_r == $past(count_r) - 1 && $stable(head_r)) else $error("filo read wrong");
  a_wmk_track: assert property ($fell(wmk) |-> count_r < thresh || thresh == '0)
    else $error("watermark dropped early");
  a_pre_history: assert property (commit && mode == asb_pkg::ASB_MODE_TRIGGER && !trig_seen_r && thr_hit
    |=> count_r == $past(count_r)) else $error("pre-trigger history grew");
  a_post_fill: assert property (commit && mode == asb_pkg::ASB_MODE_TRIGGER && trig_seen_r && !full
    |=> count_r == $past(count_r) + 1 && $stable(head_r)) else $error("post-trigger not filling");
  a_six_bytes: assert property (commit && res_high |-> byte_cnt_r == 3'(asb_pkg::SMP_BYTES_HI - 1))
    else $error("high resolution sample not six bytes");
  a_count_cap: assert property (count_r <= CW'(DEPTH) ##1 count_r <= CW'(DEPTH))
    else $error("count beyond depth");

  c_stream_wrap: cover property (commit && full && mode == asb_pkg::ASB_MODE_STREAM);
  c_filo_read:   cover property (rd_do && mode == asb_pkg::ASB_MODE_FILO);
  c_trig_full:   cover property (trig_seen_r && full && mode == asb_pkg::ASB_MODE_TRIGGER);
  c_in_stall:    cover property (!in_ready ##1 in_ready);

endmodule

`default_nettype wire

// ===== src/asb_pkg.sv
// Purpose: shared constants and types of the acceleration sample buffer
// Assumes: one clock domain, samples arrive as a byte stream
// Notes:   sample bytes are packed with the first byte in the low bits

`default_nettype none

// ****************************************
// package
// ****************************************
package asb_pkg;

  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned SMP_BYTES_HI  = 6;  // high resolution: x_l x_h y_l y_h z_l z_h
  localparam int unsigned SMP_BYTES_LO  = 3;  // low resolution: x y z
  localparam int unsigned SMP_W         = SMP_BYTES_HI * BYTE_W;
  localparam int unsigned IN_FIFO_DEPTH = 8;
  localparam int unsigned SMP_DEPTH     = 32;

  // buffer operating modes
  typedef enum logic [1:0] {
    ASB_MODE_FIFO,
    ASB_MODE_STREAM,
    ASB_MODE_TRIGGER,
    ASB_MODE_FILO
  } asb_mode_t;

  // one stored three-axis sample, first byte written in the low bits
  typedef struct packed {
    logic [7:0] z_h;
    logic [7:0] z_l;
    logic [7:0] y_h;
    logic [7:0] y_l;
    logic [7:0] x_h;
    logic [7:0] x_l;
  } asb_sample_t;

  // answer to a host sample read
  typedef struct packed {
    logic        valid;
    asb_sample_t sample;
  } asb_rd_rsp_t;

endpackage

`default_nettype wire

// ===== src/asb_byte_fifo.sv
// Purpose: small valid/ready staging fifo with a registered output stage
// Assumes: single clock, asynchronous active-low reset
// Notes:   holds DEPTH words in memory plus one in the output register

`timescale 1ns/10ps
`default_nettype none

module asb_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
    $error("asb_byte_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic             push;
  logic             load;

  // ****************************************
  // handshakes
  // ****************************************
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));  // honest full stalls the source
  assign push      = in_valid && in_ready;
  assign load      = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // storage, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (load) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      unique case ({push, load})
        2'b10:   cnt_r <= cnt_r + (AW+1)'(1);
        2'b01:   cnt_r <= cnt_r - (AW+1)'(1);
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // registered output stage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem_r[rp_r];
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== bench/asb_host_model.sv
// Purpose: host model that fetches whole samples from the buffer
// Assumes: one rd_req pulse per sample, answer one cycle later
// Notes:   gap argument lets the host be prompt or slow

`timescale 1ns/10ps
`default_nettype none

// ****************************************
// host reader
// ****************************************
module asb_host_model (
  input  wire logic                 clk_sys,
  input  wire asb_pkg::asb_rd_rsp_t rd_rsp,
  output logic                      rd_req
);
  // idle until the bench asks for a sample
  initial begin
    rd_req = 1'b0;
  end

  // request held for exactly one edge; answer taken in the cycle after it
  task automatic read(input int gap, output asb_pkg::asb_sample_t smp, output logic got);
    repeat (gap) @(negedge clk_sys);
    @(negedge clk_sys);
    rd_req = 1'b1;
    @(negedge clk_sys);
    rd_req = 1'b0;
    got = rd_rsp.valid;
    smp = rd_rsp.sample;
  endtask
endmodule

`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the mode-aware sample buffer
// Assumes: small depth so every mode reaches full quickly
// Notes:   a queue model predicts contents; random data from an lfsr

`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int unsigned D   = 4;
  localparam int unsigned CWB = $clog2(D + 1);

  logic clk_sys, arst_n, res_high, clear, trigger, in_valid, in_ready, rd_req;
  logic wmk, full, empty, trig_seen;
  logic [7:0]           in_byte;
  logic [CWB-1:0]       thresh, count;
  asb_pkg::asb_mode_t   mode;
  asb_pkg::asb_rd_rsp_t rd_rsp;
  asb_pkg::asb_sample_t q[$];
  logic [31:0]          rnd;
  int                   n_fail, cmp_count, th;
  logic                 trig;

  // ****************************************
  // design and host
  // ****************************************
  asb_sample_buffer #(.DEPTH(D), .IN_DPTH(8)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .mode(mode), .res_high(res_high), .thresh(thresh),
    .clear(clear), .trigger(trigger), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
    .rd_req(rd_req), .rd_rsp(rd_rsp), .wmk(wmk), .full(full), .empty(empty),
    .trig_seen(trig_seen), .count(count)
  );
  asb_host_model host (.clk_sys(clk_sys), .rd_rsp(rd_rsp), .rd_req(rd_req));

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // status flags follow the model count and trigger state
  task automatic check_state;
    chk(48'(count), 48'(q.size()));
    chk(48'(full), 48'(q.size() == D));
    chk(48'(empty), 48'(q.size() == 0));
    chk(48'(wmk), 48'(th != 0 && q.size() >= th));
    chk(48'(trig_seen), 48'(trig));
  endtask

  // bytes go out low byte first; a refusal is waited out under a bound
  task automatic send(input asb_pkg::asb_sample_t s, input int nb);
    int i, w;
    for (i = 0; i < nb; i++) begin
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_byte  = s[8*i +: 8];
      w = 0;
      // in_ready only moves on a rising edge, so its value now is what the next edge sees
      while (in_ready !== 1'b1) begin
        w++;
        if (w > 100) begin
          n_fail++;
          test_done;
        end
        @(negedge clk_sys);
      end
      @(posedge clk_sys);
    end
    @(negedge clk_sys);
    in_valid = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask

  // mode policy on a finished sample, then compare flags
  task automatic store(input asb_pkg::asb_sample_t s);
    if (mode == asb_pkg::ASB_MODE_FIFO || (mode == asb_pkg::ASB_MODE_TRIGGER && trig)) begin
      if (q.size() < D) q.push_back(s);
    end else if (mode == asb_pkg::ASB_MODE_TRIGGER) begin
      if ((th != 0 && q.size() >= th) || q.size() == D) void'(q.pop_front());
      q.push_back(s);
    end else begin
      if (q.size() == D) void'(q.pop_front());
      q.push_back(s);
    end
    check_state;
  endtask

  task automatic clear_buf;
    @(negedge clk_sys);
    clear = 1'b1;
    @(negedge clk_sys);
    clear = 1'b0;
    q.delete();
    trig = 1'b0;
    repeat (2) @(negedge clk_sys);
    check_state;
  endtask

  // one host read: filo takes the newest, the rest the oldest
  task automatic get;
    asb_pkg::asb_sample_t s, e;
    logic v;
    rnd = lfsr(rnd);
    e = (mode == asb_pkg::ASB_MODE_FILO) ? q.pop_back() : q.pop_front();
    host.read(int'(rnd[1:0]), s, v);
    chk(48'(v), 48'h0000_0000_0001);
    chk(s, e);
    repeat (2) @(negedge clk_sys);
    check_state;
  endtask

  // fill past full with random samples, optional trigger, drain, read empty
  task automatic run_mode(input asb_pkg::asb_mode_t m, input int t, input int ntrig);
    asb_pkg::asb_sample_t s, e;
    logic v;
    int k;
    clear_buf;
    mode   = m;
    th     = t;
    thresh = CWB'(t);
    for (k = 0; k < D + 2; k++) begin
      if (k == ntrig) begin
        @(negedge clk_sys);
        trigger = 1'b1;
        @(negedge clk_sys);
        trigger = 1'b0;
        trig = (m == asb_pkg::ASB_MODE_TRIGGER);
      end
      rnd = lfsr(rnd);
      s[31:0] = rnd;
      rnd = lfsr(rnd);
      s[47:32] = rnd[15:0];
      send(s, asb_pkg::SMP_BYTES_HI);
      store(s);
    end
    while (q.size() > 0) get;
    // a read of an empty buffer must give no answer
    host.read(0, e, v);
    chk(48'(v), 48'h0000_0000_0000);
    $display("test mode %0d done", m);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0; mode = asb_pkg::ASB_MODE_FIFO; res_high = 1'b1; thresh = '0;
    clear = 1'b0; trigger = 1'b0; in_valid = 1'b0; in_byte = 8'h00;
    rnd = 32'hfa94_ed2b; n_fail = 0; cmp_count = 0; th = 0; trig = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    check_state;
    run_mode(asb_pkg::ASB_MODE_FIFO, 2, 99);
    run_mode(asb_pkg::ASB_MODE_STREAM, 3, 99);
    run_mode(asb_pkg::ASB_MODE_FILO, 4, 2);
    run_mode(asb_pkg::ASB_MODE_TRIGGER, 2, 3);
    // threshold off: pre-trigger history only discards once full
    run_mode(asb_pkg::ASB_MODE_TRIGGER, 0, 5);
    // low resolution with a dropped partial sample
    clear_buf;
    mode = asb_pkg::ASB_MODE_FIFO;
    res_high = 1'b0;
    send(48'h0000_00a5_5a3c, 2);
    clear_buf;
    send(48'h0000_0012_3456, asb_pkg::SMP_BYTES_LO);
    store(48'h0000_0012_3456);
    get;
    $display("test low resolution done");
    test_done;
  end

  // run-length guard
  initial begin
    #3_000_000;
    n_fail++;
    test_done;
  end
endmodule

`default_nettype wire
